// *** hw/ochsel_top.sv ***
// Operation
// - Serial-mode channels 7-10 echo previous frame's on-bits in feedback byte.
// - Parallel-mode channels 7-10 echo input pin sampled at chip-select fall.
// - Feedback source chosen per channel, modes may mix in one byte.
// - On-bit register: twelve bits, low ten one per channel, 1 on, 0 off.
// - On-bit acts in every source field except 10.
// - On-bit register top two bits held at ones, never read back; reset value C00.
// - Field 0x: channel follows its on-bit alone.
// - Field 10: channel follows its direct drive pin.
// - Field 11: channel on only when on-bit and pin are both 1.
// - Bank A holds fields for channels 1-6, reset all to pin mode.
// - Bank B holds fields for channels 7-10, top four bits zero.
// - Paired channels are both driven by the lower channel's source.
// - Pairing bit 0 direct, 1 pairs with next channel; reset 0.
// - Response byte 1 from previous second byte; byte 2 from current first.
`timescale 1ns/1ps
`include "ochsel_regs.svh"

module ochsel_top
   import ochsel_pkg::*;
(
   input  wire logic       I_CLK,
   input  wire logic       I_SYS_RST,
   input  wire logic       I_CS_N,
   input  wire logic       I_SCLK,
   input  wire logic       I_SI,
   input  wire logic [9:0] I_DIRECT_DRIVE_PIN,
   output      logic       O_SO,
   output      logic       O_SO_OE,
   output      logic [9:0] O_CHANNEL_ON
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic field_src(input logic [1:0] fld,
                                      input logic       on_bit,
                                      input logic       pin);
      logic r;
      r = on_bit;
      if (fld == 2'b10)
         r = pin;
      else if (fld == 2'b11)
         r = on_bit & pin;
      return r;
   endfunction

   function automatic logic [7:0] readback(input logic [3:0]  cmd,
                                           input logic [11:0] on_b,
                                           input logic [11:0] src_a,
                                           input logic [11:0] src_b,
                                           input logic [11:0] pair);
      logic [7:0] r;
      r = 8'h00;
      case (cmd)
         `CMD_WR_ON_BITS: r = on_b[7:0];
         `CMD_WR_SRC_A:   r = src_a[7:0];
         `CMD_WR_SRC_B:   r = src_b[7:0];
         `CMD_WR_PAIRING: r = pair[7:0];
         default:         r = 8'h00;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   pins_s       raw;
   pins_s       syn;

   assign raw = '{cs_n: I_CS_N, sclk: I_SCLK, si: I_SI,
                  pins: I_DIRECT_DRIVE_PIN};

   ochsel_sync
   #(
      .WIDTH (13),
      .INIT  (13'h1000)
   )
   u_sync
   (
      .i_clk    (I_CLK),
      .i_rst    (I_SYS_RST),
      .i_async  (raw),
      .o_stable (syn)
   );

   // ****************************************************************
   // Registers and link state
   // ****************************************************************
   link_state_e state_q;
   link_state_e state_d;
   logic        cs_n_q;
   logic        sclk_q;
   logic [15:0] rx_q;
   logic [4:0]  cnt_q;
   logic [7:0]  opf_q;
   logic [7:0]  rsp_lo_q;
   logic        so_q;
   logic [7:0]  ops_q;
   logic [11:0] on_bits_q;
   logic [11:0] src_a_q;
   logic [11:0] src_b_q;
   logic [11:0] pair_q;

   logic        cs_fall;
   logic        cs_rise;
   logic        sck_rise;
   logic        sck_fall;
   logic        frame_ok;
   logic        first_byte;
   logic [15:0] rx_next;
   frame_s      frm;
   logic [7:0]  opf_d;
   logic [15:0] tx_word;
   logic [3:0]  tx_idx;
   logic        in_frame;
   logic [7:0]  rb_byte;

   assign cs_fall    = cs_n_q & ~syn.cs_n;
   assign cs_rise    = ~cs_n_q & syn.cs_n;
   assign sck_rise   = ~syn.cs_n & ~sclk_q & syn.sclk;
   assign sck_fall   = ~syn.cs_n & sclk_q & ~syn.sclk;
   assign rx_next    = {rx_q[14:0], syn.si};
   assign first_byte = sck_rise && (cnt_q == `FIRST_BYTE_BITS - 5'h01);
   assign frame_ok   = cs_rise && in_frame &&
                       (cnt_q == `FRAME_BITS);
   assign frm        = frame_s'(rx_q);
   assign tx_word    = {opf_q, rsp_lo_q};
   assign tx_idx     = 4'hF - cnt_q[3:0];

   // ****************************************************************
   // Feedback byte, per channel choice
   // ****************************************************************
   always_comb
   begin
      opf_d = ops_q;
      for (int k = 0; k < 4; k++)
      begin
         if (ops_q[k])
            opf_d[4+k] = syn.pins[6+k];
         else
            opf_d[4+k] = ops_q[4+k];
      end
   end

   // ****************************************************************
   // Frame state machine
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (cs_fall)
               state_d = ST_SHIFT;
         ST_SHIFT:
            if (cs_rise)
               state_d = ST_DONE;
         ST_DONE:
            state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         state_q <= ST_IDLE;
         cs_n_q  <= 1'b1;
         sclk_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cs_n_q  <= syn.cs_n;
         sclk_q  <= syn.sclk;
      end
   end

   // ****************************************************************
   // Shift in, shift out
   // ****************************************************************
   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         rx_q     <= 16'h0000;
         cnt_q    <= 5'h00;
         opf_q    <= 8'h00;
         rsp_lo_q <= 8'h00;
         so_q     <= 1'b0;
      end
      else if (cs_fall)
      begin
         cnt_q    <= 5'h00;
         opf_q    <= opf_d;
         rsp_lo_q <= 8'h00;
         so_q     <= opf_d[7];
      end
      else if (sck_rise)
      begin
         rx_q  <= rx_next;
         if (cnt_q != 5'h1F)
            cnt_q <= cnt_q + 5'h01;
         if (first_byte)
            rsp_lo_q <= rb_byte;
      end
      else if (sck_fall && cnt_q < `FRAME_BITS)
      begin
         so_q <= tx_word[tx_idx];
      end
   end

   assign O_SO    = so_q;
   assign O_SO_OE = ~syn.cs_n;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   logic        wr_ops;
   logic        wr_on_bits;
   logic        wr_src_a;
   logic        wr_src_b;
   logic        wr_pairing;
   logic [7:0]  ops_fields;

   assign in_frame   = (state_q == ST_SHIFT);
   assign wr_ops     = frame_ok && (frm.cmd == `CMD_OPS);
   assign wr_on_bits = frame_ok && (frm.cmd == `CMD_WR_ON_BITS);
   assign wr_src_a   = frame_ok && (frm.cmd == `CMD_WR_SRC_A);
   assign wr_src_b   = frame_ok && (frm.cmd == `CMD_WR_SRC_B);
   assign wr_pairing = frame_ok && (frm.cmd == `CMD_WR_PAIRING);
   assign ops_fields = {frm.data[3], 1'b0, frm.data[2], 1'b0,
                        frm.data[1], 1'b0, frm.data[0], 1'b0};
   assign rb_byte    = readback(rx_next[7:4], on_bits_q, src_a_q,
                                src_b_q, pair_q);

   // ****************************************************************
   // Register writes at frame end
   // ****************************************************************
   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         ops_q     <= `OPS_RST;
         on_bits_q <= `ON_BITS_RST;
         src_a_q   <= `SRC_A_RST;
         src_b_q   <= `SRC_B_RST;
         pair_q    <= `PAIRING_RST;
      end
      else
      begin
         if (wr_ops)
            ops_q <= frm.data[7:0];
         if (wr_on_bits)
            on_bits_q <= frm.data | `ON_BITS_TOP;
         else if (wr_ops)
            on_bits_q[9:6] <= frm.data[7:4];
         if (wr_src_a)
            src_a_q <= frm.data;
         if (wr_src_b)
            src_b_q <= frm.data & `SRC_B_MASK;
         else if (wr_ops)
            src_b_q[7:0] <= ops_fields;
         if (wr_pairing)
            pair_q <= frm.data & `PAIRING_MASK;
      end
   end

   // ****************************************************************
   // Channel command
   // ****************************************************************
   logic [19:0] fields;
   logic [9:0]  src;
   logic [9:0]  pair_into;
   logic [9:0]  drive;

   assign fields    = {src_b_q[7:0], src_a_q};
   assign pair_into = {pair_q[7], pair_q[6], pair_q[5], 1'b0, pair_q[4],
                       1'b0, pair_q[2], pair_q[1], pair_q[0], 1'b0};

   always_comb
   begin
      for (int i = 0; i < 10; i++)
         src[i] = field_src(fields[2*i +: 2], on_bits_q[i],
                            syn.pins[i]);
   end

   always_comb
   begin
      drive[0] = src[0];
      for (int i = 1; i < 10; i++)
         drive[i] = pair_into[i] ? drive[i-1] : src[i];
   end

   assign O_CHANNEL_ON = drive;

endmodule // ochsel_top

// *** hw/ochsel_regs.svh ***
`ifndef OCHSEL_REGS_SVH
`define OCHSEL_REGS_SVH

// ****************************************************************
// Frame commands
// ****************************************************************
`define CMD_OPS            4'h1
`define CMD_WR_ON_BITS     4'h2
`define CMD_WR_SRC_A       4'h3
`define CMD_WR_SRC_B       4'h4
`define CMD_WR_PAIRING     4'h5

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define ON_BITS_RST        12'hC00
`define ON_BITS_TOP        12'hC00
`define SRC_A_RST          12'hAAA
`define SRC_B_RST          12'h0AA
`define SRC_B_MASK         12'h0FF
`define PAIRING_RST        12'h000
`define PAIRING_MASK       12'h0F7
`define OPS_RST            8'h00

// ****************************************************************
// Frame layout and timing
// ****************************************************************
`define FRAME_BITS         5'h10
`define FIRST_BYTE_BITS    5'h08
`define SYNC_STAGES        3

`endif

// *** hw/ochsel_pkg.sv ***
package ochsel_pkg;

   typedef struct packed
   {
      logic [3:0]  cmd;
      logic [11:0] data;
   } frame_s;

   typedef struct packed
   {
      logic       cs_n;
      logic       sclk;
      logic       si;
      logic [9:0] pins;
   } pins_s;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE  = 2'b11
   } link_state_e;

endpackage

// *** hw/ochsel_sync.sv ***
`timescale 1ns/1ps
`include "ochsel_regs.svh"

module ochsel_sync
#(
   parameter int          WIDTH = 13,
   parameter [WIDTH-1:0]  INIT  = '0
)
(
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output      logic [WIDTH-1:0] o_stable
);

   // ****************************************************************
   // Three stages, change accepted when second and third agree
   // ****************************************************************
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] stable_d;

   assign agree    = ~(s2_q ^ s3_q);
   assign stable_d = (agree & s3_q) | (~agree & stable_q);
   assign o_stable = stable_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s1_q     <= INIT;
         s2_q     <= INIT;
         s3_q     <= INIT;
         stable_q <= INIT;
      end
      else
      begin
         s1_q     <= i_async;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         stable_q <= stable_d;
      end
   end

endmodule // ochsel_sync

// *** testbench/ochsel_top_sva.sv ***
`timescale 1ns/1ps
// ******
// Port checker
// ******
module ochsel_sva
(
   input wire logic       I_CLK,
   input wire logic       I_SYS_RST,
   input wire logic       I_CS_N,
   input wire logic       I_SCLK,
   input wire logic [9:0] I_DIRECT_DRIVE_PIN,
   input wire logic       O_SO,
   input wire logic       O_SO_OE,
   input wire logic [9:0] O_CHANNEL_ON
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);

   sequence cs_quiet;
      I_CS_N [*8];
   endsequence
   sequence pins_still;
      $stable(I_DIRECT_DRIVE_PIN) [*8];
   endsequence

   reset_out_a: assert property ($fell(I_SYS_RST) |->
      !O_SO_OE && !O_SO && O_CHANNEL_ON == 10'h000)
      else $error("outputs wrong at reset release");
   oe_on_a: assert property ($fell(I_CS_N) |-> ##[2:5] O_SO_OE)
      else $error("serial output not enabled");
   oe_off_a: assert property ($rose(I_CS_N) |-> ##[2:5] !O_SO_OE)
      else $error("serial output not released");
   oe_idle_a: assert property (I_CS_N [*6] |-> !O_SO_OE)
      else $error("serial output driven when idle");
   so_hold_a: assert property (I_SCLK [*8] |-> $stable(O_SO))
      else $error("serial output moved in high phase");
   so_idle_a: assert property (cs_quiet |-> $stable(O_SO))
      else $error("serial output moved between frames");
   out_quiet_a: assert property (cs_quiet and pins_still |->
      $stable(O_CHANNEL_ON))
      else $error("channel moved without cause");
   out_frame_a: assert property
      ((!I_CS_N && $stable(I_DIRECT_DRIVE_PIN)) [*8] |-> $stable(O_CHANNEL_ON))
      else $error("channel moved inside a frame");
endmodule // ochsel_sva

bind ochsel_top ochsel_sva chk
(
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CS_N(I_CS_N), .I_SCLK(I_SCLK),
   .I_DIRECT_DRIVE_PIN(I_DIRECT_DRIVE_PIN), .O_SO(O_SO),
   .O_SO_OE(O_SO_OE), .O_CHANNEL_ON(O_CHANNEL_ON)
);

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ps
// ******
// Serial host model
// ******
module spi_host_model
(
   input  wire logic i_clk,
   input  wire logic i_so,
   output      logic o_cs_n,
   output      logic o_sclk,
   output      logic o_si
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
   end

   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      o_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         o_si = tx[i];
         repeat (8) @(negedge i_clk);
         rx[i] = i_so;
         o_sclk = 1'b1;
         repeat (8) @(negedge i_clk);
         o_sclk = 1'b0;
      end
      repeat (8) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (8) @(negedge i_clk);
   endtask
endmodule // spi_host_model

// *** testbench/output_channel_control_select_bench.sv ***
`timescale 1ns/1ps
`include "ochsel_regs.svh"
// ******
// Bench top
// ******
module output_channel_control_select_bench
   import ochsel_pkg::*;
;
   logic        clk, rst, cs_n, sclk, si, so, so_oe;
   logic [9:0]  pin, chan;
   logic [15:0] rx;
   int          miscompares = 0, total_checks = 0, cycles = 0;

   ochsel_top uut
   (
      .I_CLK(clk), .I_SYS_RST(rst), .I_CS_N(cs_n), .I_SCLK(sclk),
      .I_SI(si), .I_DIRECT_DRIVE_PIN(pin), .O_SO(so), .O_SO_OE(so_oe),
      .O_CHANNEL_ON(chan)
   );
   spi_host_model host
   (
      .i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   // ******
   // Helpers
   // ******
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [3:0] c, input logic [11:0] d);
      frame_s f;
      f.cmd = c;
      f.data = d;
      host.xfer(f, rx);
   endtask
   task automatic drive(input logic [9:0] p);
      @(negedge clk);
      pin = p;
      repeat (6) @(negedge clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ******
   // Scenarios
   // ******
   task automatic test_reset();
      drive(10'h2A5);
      check(chan, 10'h2A5);
      check(so_oe, 1'b0);
      send(`CMD_WR_SRC_A, 12'hAAA);
      check(rx[7:0], 8'hAA);
      send(`CMD_WR_SRC_B, 12'h0AA);
      check(rx[7:0], 8'hAA);
      send(`CMD_WR_ON_BITS, 12'h155);
      check(rx[7:0], 8'h00);
      send(`CMD_WR_PAIRING, 12'h0FF);
      check(rx[7:0], 8'h00);
      $display("reset test done");
   endtask
   task automatic test_modes();
      send(`CMD_WR_PAIRING, 12'h000);
      check(rx[7:0], 8'hF7);
      send(`CMD_WR_SRC_A, 12'h000);
      send(`CMD_WR_SRC_B, 12'h000);
      drive(10'h3FF);
      check(chan, 10'h155);
      send(`CMD_WR_SRC_A, 12'h555);
      send(`CMD_WR_SRC_B, 12'h055);
      drive(10'h000);
      check(chan, 10'h155);
      send(`CMD_WR_SRC_A, 12'hFFF);
      check(rx[7:0], 8'h55);
      send(`CMD_WR_SRC_B, 12'h1FF);
      drive(10'h0F0);
      check(chan, 10'h050);
      send(`CMD_WR_SRC_A, 12'hAAA);
      send(`CMD_WR_SRC_B, 12'h0AA);
      check(chan, 10'h0F0);
      $display("mode test done");
   endtask
   task automatic test_pairing();
      send(`CMD_WR_SRC_A, 12'h000);
      send(`CMD_WR_SRC_B, 12'h000);
      send(`CMD_WR_ON_BITS, 12'h041);
      check(rx[7:0], 8'h55);
      send(`CMD_WR_PAIRING, 12'h021);
      check(chan, 10'h0C3);
      send(`CMD_WR_PAIRING, 12'h000);
      check(chan, 10'h041);
      $display("pairing test done");
   endtask
   task automatic test_feedback();
      drive(10'h180);
      send(`CMD_OPS, 12'h0A5);
      check(rx, 16'h0000);
      check(chan[9:6], 4'hE);
      send(`CMD_OPS, 12'h000);
      check(rx, 16'hE500);
      check(chan[9:6], 4'h0);
      send(`CMD_WR_ON_BITS, 12'h001);
      check(rx, 16'h0001);
      send(4'h0, 12'hFFF);
      check(rx, 16'h0000);
      check(chan, 10'h001);
      $display("feedback test done");
   endtask

   initial
   begin
      rst = 1'b1;
      pin = 10'h000;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      test_reset();
      test_modes();
      test_pairing();
      test_feedback();
      give_verdict();
   end
endmodule // output_channel_control_select_bench
